// ==== rtl/ddadma_seq.sv ====
// Single-channel dual-address DMA transfer sequencer
`timescale 1ns/10ps
`default_nettype none
module ddadma_seq
  import ddadma_pkg::*;
#(
  parameter int ADDR_W = PTR_W,
  parameter int DEPTH  = FIFO_DEPTH
) (
  input  wire logic              ref_clk_i,
  input  wire logic              resetn_i,
  input  wire logic              start_i,
  input  wire logic [1:0]        reqg_i,
  input  wire logic [1:0]        src_size_i,
  input  wire logic [1:0]        dst_size_i,
  input  wire logic              src_inc_en_i,
  input  wire logic              dst_inc_en_i,
  input  wire logic              bus16_i,
  input  wire logic              periph_is_dst_i,
  input  wire logic              intr_en_i,
  input  wire logic [7:0]        fc_reg_i,
  input  wire logic [ADDR_W-1:0] src_ptr_i,
  input  wire logic [ADDR_W-1:0] dst_ptr_i,
  input  wire logic [CNT_W-1:0]  byte_count_i,
  input  wire logic              dma_request_line_n_i,
  input  wire logic              done_in_n_i,
  input  wire logic              bus_data_transfer_acknowledge_i,
  input  wire logic              bus_err_i,
  input  wire logic [DATA_W-1:0] bus_rdata_i,
  output wire logic              dma_acknowledge_line_n_o,
  output wire logic              done_out_n_o,
  output wire logic              done_oe_n_o,
  output wire logic              bus_strobe_o,
  output wire logic              bus_read_o,
  output wire logic              bus_word_o,
  output wire logic [ADDR_W-1:0] bus_addr_o,
  output wire logic [FC_W-1:0]   bus_fc_o,
  output wire logic [DATA_W-1:0] bus_wdata_o,
  output wire logic              busy_o,
  output wire logic              block_done_o,
  output wire logic              bus_error_o,
  output wire logic              irq_o,
  output wire logic [ADDR_W-1:0] src_ptr_o,
  output wire logic [ADDR_W-1:0] dst_ptr_o,
  output wire logic [CNT_W-1:0]  count_o
);
  // ***************************************************************
  // State
  // ***************************************************************
  ddadma_state_t     state_r, state_nxt;
  logic [ADDR_W-1:0] src_ptr_r, src_ptr_nxt, dst_ptr_r, dst_ptr_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic [DATA_W-1:0] hold_r, hold_nxt, wdata_r, wdata_nxt;
  logic [FC_W-1:0]   fc_r, fc_nxt;
  logic beat_r, beat_nxt, two_rd_r, two_rd_nxt, two_wr_r, two_wr_nxt;
  logic rd_word_r, rd_word_nxt, wr_word_r, wr_word_nxt;
  logic s_str_r, s_str_nxt, d_str_r, d_str_nxt, two_b_r, two_b_nxt;
  logic last_op_r, last_op_nxt, term_r, term_nxt, err_r, err_nxt;
  logic start_q_r, dma_request_line_q_r, pend_r, pend_nxt;
  logic strobe_r, strobe_nxt, rw_r, rw_nxt, word_r, word_nxt;
  logic dma_acknowledge_line_n_r, dma_acknowledge_line_n_nxt, done_n_r, done_n_nxt, oe_n_r, oe_n_nxt;
  logic busy_r, busy_nxt, fin_r, fin_nxt, irq_r, irq_nxt;
  // ***************************************************************
  // Operand plan, decoded from sizes, parity and count
  // ***************************************************************
  logic              s_word, d_word, two_b, rd_word, wr_word;
  logic              ext, req_ok, wr_final, cyc_end;
  logic [2:0]        src_step, dst_step;
  logic [ADDR_W-1:0] src_addr, dst_addr;
  logic [CNT_W-1:0]  cnt_step;
  logic [7:0]        rd_byte, wr_byte;
  logic              push, pop, fifo_in_ready, fifo_out_valid;
  logic [DATA_W-1:0] fifo_head;

  // Reserved size codes fall back to byte handling
  assign s_word  = bus16_i && (src_size_i == SIZE_WORD);
  assign d_word  = bus16_i && (dst_size_i == SIZE_WORD);
  // A final single byte shrinks the operand to one byte
  assign two_b   = (s_word || d_word) && (cnt_r != 16'h1);
  // Odd word addresses split into two byte cycles
  assign rd_word = s_word && two_b && !src_ptr_r[0];
  assign wr_word = d_word && two_b && !dst_ptr_r[0];
  assign ext     = reqg_i[1];
  // Internal modes never look at the request line
  assign req_ok  = !ext ? 1'b1 :
                   (reqg_i == REQG_EXT_BURST) ? !dma_request_line_n_i : pend_r;
  assign wr_final = beat_r || !two_wr_r;
  assign cyc_end  = strobe_r && (bus_data_transfer_acknowledge_i || bus_err_i);

  // Byte-lane peripheral: stride of two per cycle, four per operand
  assign src_step = !src_inc_en_i ? 3'h0 : rd_word_r ? 3'h2 :
                    two_rd_r ? (s_str_r ? 3'h4 : 3'h2) :
                    (s_str_r ? 3'h2 : 3'h1);
  assign dst_step = !dst_inc_en_i ? 3'h0 : wr_word_r ? 3'h2 :
                    two_wr_r ? (d_str_r ? 3'h4 : 3'h2) :
                    (d_str_r ? 3'h2 : 3'h1);
  assign src_addr = src_ptr_r +
                    ADDR_W'({beat_r && s_str_r, beat_r && !s_str_r});
  assign dst_addr = dst_ptr_r +
                    ADDR_W'({beat_r && d_str_r, beat_r && !d_str_r});
  assign cnt_step = {{(CNT_W-2){1'b0}}, two_b_r, !two_b_r};
  // Even address sits on the upper lane of a 16-bit bus
  assign rd_byte  = (!bus16_i || addr_r[0]) ? bus_rdata_i[7:0]
                                            : bus_rdata_i[15:8];
  assign wr_byte  = beat_r ? fifo_head[7:0] : fifo_head[15:8];

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  always_comb begin
    state_nxt   = state_r;
    src_ptr_nxt = src_ptr_r;
    dst_ptr_nxt = dst_ptr_r;
    cnt_nxt     = cnt_r;
    hold_nxt    = hold_r;
    wdata_nxt   = wdata_r;
    addr_nxt    = addr_r;
    fc_nxt      = fc_r;
    beat_nxt    = beat_r;
    two_rd_nxt  = two_rd_r;
    two_wr_nxt  = two_wr_r;
    rd_word_nxt = rd_word_r;
    wr_word_nxt = wr_word_r;
    s_str_nxt   = s_str_r;
    d_str_nxt   = d_str_r;
    two_b_nxt   = two_b_r;
    last_op_nxt = last_op_r;
    term_nxt    = term_r;
    err_nxt     = err_r;
    pend_nxt    = pend_r;
    strobe_nxt  = strobe_r;
    rw_nxt      = rw_r;
    word_nxt    = word_r;
    dma_acknowledge_line_n_nxt  = dma_acknowledge_line_n_r;
    done_n_nxt  = done_n_r;
    oe_n_nxt    = oe_n_r;
    busy_nxt    = busy_r;
    fin_nxt     = 1'b0;
    irq_nxt     = 1'b0;
    push        = 1'b0;
    pop         = 1'b0;
    if (cyc_end) begin
      strobe_nxt = 1'b0;
      dma_acknowledge_line_n_nxt = 1'b1;
      done_n_nxt = 1'b1;
      oe_n_nxt   = 1'b1;
    end
    // Sampled only while this end is not driving the line
    if (strobe_r && oe_n_r && !done_in_n_i && (!ext || !dma_acknowledge_line_n_r)) begin
      term_nxt = 1'b1;
    end
    case (state_r)
      ST_IDLE: begin
        if (start_i && !start_q_r) begin
          src_ptr_nxt = src_ptr_i;
          dst_ptr_nxt = dst_ptr_i;
          cnt_nxt     = byte_count_i; // Zero means 64K bytes
          term_nxt    = 1'b0;
          err_nxt     = 1'b0;
          busy_nxt    = 1'b1;
          state_nxt   = ST_INIT;
        end
      end
      ST_INIT: begin
        state_nxt = ST_WAITREQ;
      end
      ST_WAITREQ: begin
        // A cleared start parks the channel between operands
        if (start_i && req_ok) begin
          two_b_nxt   = two_b;
          rd_word_nxt = rd_word;
          wr_word_nxt = wr_word;
          two_rd_nxt  = two_b && !rd_word;
          two_wr_nxt  = two_b && !wr_word;
          s_str_nxt   = bus16_i && !s_word && d_word;
          d_str_nxt   = bus16_i && s_word && !d_word;
          last_op_nxt = two_b ? (cnt_r == 16'h2) : (cnt_r == 16'h1);
          beat_nxt    = 1'b0;
          pend_nxt    = 1'b0;
          state_nxt   = ST_READ;
        end
      end
      ST_READ: begin
        if (!strobe_r) begin
          strobe_nxt = 1'b1;
          rw_nxt     = 1'b1;
          word_nxt   = rd_word_r;
          addr_nxt   = src_addr;
          fc_nxt     = fc_reg_i[SFC_LSB +: FC_W];
          dma_acknowledge_line_n_nxt = !(ext && !periph_is_dst_i);
        end else if (bus_err_i) begin
          err_nxt   = 1'b1;
          state_nxt = ST_TERM;
        end else if (bus_data_transfer_acknowledge_i) begin
          if (rd_word_r) begin
            hold_nxt = bus_rdata_i;
          end else if (beat_r) begin
            hold_nxt[7:0] = rd_byte;
          end else begin
            hold_nxt[15:8] = rd_byte;
          end
          if (beat_r || !two_rd_r) begin
            src_ptr_nxt = src_ptr_r + ADDR_W'(src_step);
            state_nxt   = ST_PUSH;
          end else begin
            beat_nxt = 1'b1;
          end
        end
      end
      ST_PUSH: begin
        // Full FIFO holds the write phase back
        if (fifo_in_ready) begin
          push      = 1'b1;
          beat_nxt  = 1'b0;
          state_nxt = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (!strobe_r) begin
          if (fifo_out_valid) begin
            strobe_nxt = 1'b1;
            rw_nxt     = 1'b0;
            word_nxt   = wr_word_r;
            addr_nxt   = dst_addr;
            fc_nxt     = fc_reg_i[DFC_LSB +: FC_W];
            wdata_nxt  = wr_word_r ? fifo_head : {wr_byte, wr_byte};
            dma_acknowledge_line_n_nxt = !(ext && periph_is_dst_i);
            if (last_op_r && wr_final) begin
              done_n_nxt = 1'b0;
              oe_n_nxt   = 1'b0;
            end
          end
        end else if (bus_err_i) begin
          pop       = 1'b1;
          err_nxt   = 1'b1;
          state_nxt = ST_TERM;
        end else if (bus_data_transfer_acknowledge_i) begin
          if (wr_final) begin
            pop         = 1'b1;
            dst_ptr_nxt = dst_ptr_r + ADDR_W'(dst_step);
            cnt_nxt     = cnt_r - cnt_step;
            state_nxt   = (last_op_r || term_nxt) ? ST_TERM : ST_WAITREQ;
          end else begin
            beat_nxt = 1'b1;
          end
        end
      end
      ST_TERM: begin
        fin_nxt   = 1'b1;
        irq_nxt   = intr_en_i;
        busy_nxt  = 1'b0;
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // New edge wins over the clear at operand start
    if (ext && (reqg_i == REQG_EXT_STEAL) && start_i &&
        dma_request_line_q_r && !dma_request_line_n_i) begin
      pend_nxt = 1'b1;
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r   <= ST_IDLE;
      src_ptr_r <= PTR_RST;
      dst_ptr_r <= PTR_RST;
      addr_r    <= PTR_RST;
      cnt_r     <= CNT_RST;
      hold_r    <= DATA_RST;
      wdata_r   <= DATA_RST;
      fc_r      <= FC_RST;
      beat_r    <= 1'b0;
      two_rd_r  <= 1'b0;
      two_wr_r  <= 1'b0;
      rd_word_r <= 1'b0;
      wr_word_r <= 1'b0;
      s_str_r   <= 1'b0;
      d_str_r   <= 1'b0;
      two_b_r   <= 1'b0;
      last_op_r <= 1'b0;
      term_r    <= 1'b0;
      err_r     <= 1'b0;
      start_q_r <= 1'b0;
      dma_request_line_q_r  <= 1'b1;
      pend_r    <= 1'b0;
      strobe_r  <= 1'b0;
      rw_r      <= 1'b1;
      word_r    <= 1'b0;
      dma_acknowledge_line_n_r  <= 1'b1;
      done_n_r  <= 1'b1;
      oe_n_r    <= 1'b1;
      busy_r    <= 1'b0;
      fin_r     <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      src_ptr_r <= src_ptr_nxt;
      dst_ptr_r <= dst_ptr_nxt;
      addr_r    <= addr_nxt;
      cnt_r     <= cnt_nxt;
      hold_r    <= hold_nxt;
      wdata_r   <= wdata_nxt;
      fc_r      <= fc_nxt;
      beat_r    <= beat_nxt;
      two_rd_r  <= two_rd_nxt;
      two_wr_r  <= two_wr_nxt;
      rd_word_r <= rd_word_nxt;
      wr_word_r <= wr_word_nxt;
      s_str_r   <= s_str_nxt;
      d_str_r   <= d_str_nxt;
      two_b_r   <= two_b_nxt;
      last_op_r <= last_op_nxt;
      term_r    <= term_nxt;
      err_r     <= err_nxt;
      start_q_r <= start_i;
      dma_request_line_q_r  <= dma_request_line_n_i;
      pend_r    <= pend_nxt;
      strobe_r  <= strobe_nxt;
      rw_r      <= rw_nxt;
      word_r    <= word_nxt;
      dma_acknowledge_line_n_r  <= dma_acknowledge_line_n_nxt;
      done_n_r  <= done_n_nxt;
      oe_n_r    <= oe_n_nxt;
      busy_r    <= busy_nxt;
      fin_r     <= fin_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // ***************************************************************
  // Operand FIFO and outputs
  // ***************************************************************
  ddadma_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (hold_r),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_head)
  );

  assign dma_acknowledge_line_n_o     = dma_acknowledge_line_n_r;
  assign done_out_n_o = done_n_r;
  assign done_oe_n_o  = oe_n_r;
  assign bus_strobe_o = strobe_r;
  assign bus_read_o   = rw_r;
  assign bus_word_o   = word_r;
  assign bus_addr_o   = addr_r;
  assign bus_fc_o     = fc_r;
  assign bus_wdata_o  = wdata_r;
  assign busy_o       = busy_r;
  assign block_done_o = fin_r;
  assign bus_error_o  = err_r;
  assign irq_o        = irq_r;
  assign src_ptr_o    = src_ptr_r;
  assign dst_ptr_o    = dst_ptr_r;
  assign count_o      = cnt_r;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  chk_dma_acknowledge_line_internal: assert property (
    !ext |-> dma_acknowledge_line_n_o) else $error("acknowledge in internal mode");
  chk_dma_acknowledge_line_side: assert property (
    !dma_acknowledge_line_n_o |-> bus_strobe_o && (bus_read_o == !periph_is_dst_i))
    else $error("acknowledge on wrong side");
  chk_done_last: assert property (
    !done_oe_n_o |-> !done_out_n_o && !bus_read_o && last_op_r)
    else $error("last-transfer driven outside final write");
  chk_start_delay: assert property (
    state_r == ST_IDLE && start_i && !start_q_r |=>
    state_r == ST_INIT ##1 state_r == ST_WAITREQ)
    else $error("start not followed by request phase");
  chk_read_first: assert property (
    bus_strobe_o && !bus_read_o |-> fifo_out_valid)
    else $error("write without a fully read operand");
  chk_src_hold: assert property (
    !src_inc_en_i && state_r != ST_IDLE |=> $stable(src_ptr_r))
    else $error("source pointer moved while disabled");
  chk_cnt_step: assert property (
    state_r == ST_WRITE && strobe_r && bus_data_transfer_acknowledge_i && !bus_err_i &&
    wr_final |=> cnt_r == $past(cnt_r) - $past(cnt_step))
    else $error("count not reduced by operand bytes");
  chk_irq_gate: assert property (
    irq_o |-> $past(state_r == ST_TERM && intr_en_i))
    else $error("interrupt without enable or termination");
  chk_word_bus16: assert property (
    bus_strobe_o && bus_word_o |-> bus16_i)
    else $error("word cycle on 8-bit bus");

  cov_block_end:   cover property (state_r == ST_TERM && !err_r);
  cov_done_driven: cover property (!done_oe_n_o);
  cov_two_reads:   cover property (state_r == ST_READ && beat_r && two_rd_r);
endmodule
`default_nettype wire

// ==== rtl/ddadma_pkg.sv ====
// Constants and types shared by the dual-address DMA transfer sequencer
//
// Summary of operation
// - Peripheral asserts low request; external modes then start servicing it
// - Acknowledge low only during bus cycles aimed at the requesting peripheral
// - Internal request modes ignore request and never assert acknowledge
// - Internal modes drive last-transfer low during the block's final bus cycle
// - Last-transfer pulled low by others in internal mode ends the block
// - External modes: peripheral pulling last-transfer low ends the block
// - When the count runs out last-transfer is driven, never sampled
// - Block runs init, transfer, termination; interrupt only when enabled
// - Dual address only: operand fully read, then fully written
// - Reads use source pointer, source code, source size; latch on acknowledge
// - Source pointer advances only after the whole operand was read
// - Writes use destination pointer and code; then advance and count down
// - 8-bit bus ignores sizes; one read and one write per byte
// - Equal sizes: no packing; odd word address splits into byte cycles
// - Unequal sizes pack: byte source reads twice, byte destination writes twice
// - 16-bit bus uses two to four cycles per operand
// - Pointer steps follow bus width and the size combination
// - Byte-lane peripheral set to byte size, opposite a word-size side, advances by four
// - Acknowledge follows the peripheral on source or destination side
// - Count drops per byte, stops at zero; zero start means 64K
// - Size fields: 01 byte, 10 word, others reserved
// - Internal mode requests the bus one clock after start; code reaches ST_WAITREQ two clocks after start, via ST_INIT
// - Pointers are 24 bits and wrap to zero
package ddadma_pkg;
  // ***************************************************************
  // Widths and depths
  // ***************************************************************
  localparam int PTR_W      = 24;
  localparam int CNT_W      = 16;
  localparam int DATA_W     = 16;
  localparam int FC_W       = 3;
  localparam int FIFO_DEPTH = 16;
  // ***************************************************************
  // Field codes and positions
  // ***************************************************************
  localparam logic [1:0] REQG_INT_LIMIT = 2'h0;
  localparam logic [1:0] REQG_INT_MAX   = 2'h1;
  localparam logic [1:0] REQG_EXT_BURST = 2'h2;
  localparam logic [1:0] REQG_EXT_STEAL = 2'h3;
  localparam logic [1:0] SIZE_BYTE      = 2'h1;
  localparam logic [1:0] SIZE_WORD      = 2'h2;
  localparam int         SFC_LSB        = 4;
  localparam int         DFC_LSB        = 0;
  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [PTR_W-1:0]  PTR_RST  = 24'h0;
  localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0;
  localparam logic [FC_W-1:0]   FC_RST   = 3'h0;
  // ***************************************************************
  // Sequencer states
  // ***************************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_INIT, ST_WAITREQ, ST_READ, ST_PUSH, ST_WRITE, ST_TERM
  } ddadma_state_t;
endpackage

// ==== rtl/ddadma_fifo.sv ====
// Operand FIFO between the read and the write phase
`timescale 1ns/10ps
`default_nettype none
module ddadma_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             in_valid_i,
  output wire logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output wire logic             out_valid_o,
  input  wire logic             out_ready_i,
  output wire logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      wp_nxt;
  logic [AW:0]      rp_r;
  logic [AW:0]      rp_nxt;
  logic             full;
  logic             empty;
  logic             do_push;
  logic             do_pop;

  assign full        = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty       = (wp_r == rp_r);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rp_r[AW-1:0]];
  assign do_push     = in_valid_i && !full;
  assign do_pop      = out_ready_i && !empty;

  always_comb begin
    wp_nxt = wp_r + (AW+1)'(do_push);
    rp_nxt = rp_r + (AW+1)'(do_pop);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // Storage is not reset; only the pointers define content
  always_ff @(posedge ref_clk_i) begin
    if (do_push) begin
      mem[wp_r[AW-1:0]] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// ==== verification/ddadma_mem.sv ====
// Bus-side memory model answering strobed cycles
`timescale 1ns/10ps
`default_nettype none
module ddadma_mem
  import ddadma_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              resetn_i,
  input  wire logic              go_i,
  input  wire logic              bus_strobe_i,
  input  wire logic              bus_read_i,
  input  wire logic [PTR_W-1:0]  bus_addr_i,
  output var  logic              bus_data_transfer_acknowledge_o,
  output var  logic [DATA_W-1:0] bus_rdata_o
);
  // Go low stretches a cycle, as a slow device would
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_data_transfer_acknowledge_o <= 1'b0;
      bus_rdata_o <= 16'h0;
    end else begin
      bus_data_transfer_acknowledge_o <= bus_strobe_i && !bus_data_transfer_acknowledge_o && go_i;
      // Released data toggles so a stale value never looks valid
      bus_rdata_o <= (bus_strobe_i && bus_read_i) ?
                     (bus_addr_i[15:0] ^ 16'h5a3c) : ~bus_rdata_o;
    end
  end
endmodule
`default_nettype wire

// ==== verification/ddadma_seq_tb.sv ====
// Self-checking bench for the dual-address DMA sequencer
`timescale 1ns/10ps
`default_nettype none
module ddadma_seq_tb;
  import ddadma_pkg::*;
  logic              ref_clk_i, resetn_i, start_i, go, bus_err_i;
  logic [1:0]        reqg_i, src_size_i, dst_size_i;
  logic              src_inc_en_i, dst_inc_en_i, bus16_i, periph_is_dst_i;
  logic              intr_en_i, dma_request_line_n_i;
  logic [7:0]        fc_reg_i;
  logic [PTR_W-1:0]  src_ptr_i, dst_ptr_i, la;
  logic [CNT_W-1:0]  byte_count_i;
  logic [31:0]       seed, ds_r;
  wire logic         bus_data_transfer_acknowledge_i, done_in_n_i, dma_acknowledge_line_n_o, done_out_n_o;
  wire logic         done_oe_n_o, bus_strobe_o, bus_read_o, bus_word_o;
  wire logic         busy_o, block_done_o, bus_error_o, irq_o;
  wire logic [DATA_W-1:0] bus_rdata_i, bus_wdata_o;
  wire logic [PTR_W-1:0]  bus_addr_o, src_ptr_o, dst_ptr_o;
  wire logic [FC_W-1:0]   bus_fc_o;
  wire logic [CNT_W-1:0]  count_o;
  int bad_count, samples_checked, rd, wr, lastc, irqs, dones, exp_tot;
  // Last-transfer wire has a pull-up; nobody outside drives it here
  assign done_in_n_i = done_oe_n_o ? 1'b1 : done_out_n_o;
  ddadma_seq u_ddadma_seq (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .start_i(start_i), .reqg_i(reqg_i), .src_size_i(src_size_i),
    .dst_size_i(dst_size_i), .src_inc_en_i(src_inc_en_i),
    .dst_inc_en_i(dst_inc_en_i), .bus16_i(bus16_i),
    .periph_is_dst_i(periph_is_dst_i), .intr_en_i(intr_en_i),
    .fc_reg_i(fc_reg_i), .src_ptr_i(src_ptr_i), .dst_ptr_i(dst_ptr_i),
    .byte_count_i(byte_count_i), .dma_request_line_n_i(dma_request_line_n_i),
    .done_in_n_i(done_in_n_i), .bus_data_transfer_acknowledge_i(bus_data_transfer_acknowledge_i),
    .bus_err_i(bus_err_i), .bus_rdata_i(bus_rdata_i), .dma_acknowledge_line_n_o(dma_acknowledge_line_n_o),
    .done_out_n_o(done_out_n_o), .done_oe_n_o(done_oe_n_o),
    .bus_strobe_o(bus_strobe_o), .bus_read_o(bus_read_o),
    .bus_word_o(bus_word_o), .bus_addr_o(bus_addr_o), .bus_fc_o(bus_fc_o),
    .bus_wdata_o(bus_wdata_o), .busy_o(busy_o), .block_done_o(block_done_o),
    .bus_error_o(bus_error_o), .irq_o(irq_o), .src_ptr_o(src_ptr_o),
    .dst_ptr_o(dst_ptr_o), .count_o(count_o));
  ddadma_mem u_ddadma_mem (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .go_i(go), .bus_strobe_i(bus_strobe_o), .bus_read_i(bus_read_o),
    .bus_addr_i(bus_addr_o), .bus_data_transfer_acknowledge_o(bus_data_transfer_acknowledge_i),
    .bus_rdata_o(bus_rdata_i));
  always #50 ref_clk_i = ~ref_clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p,
    input logic en, input int inc, input int ops);
    return en ? p + PTR_W'(inc * ops) : p;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Handshake peripheral: random request level, random answer speed
  always @(posedge ref_clk_i) begin
    ds_r = lfsr(ds_r);
    dma_request_line_n_i <= ds_r[3] & ds_r[7];
    go <= ds_r[5] | ds_r[9];
  end
  always @(posedge ref_clk_i) begin
    if (bus_strobe_o && bus_data_transfer_acknowledge_i) begin
      if (bus_read_o) begin
        rd++;
        la = bus_addr_o;
        check(bus_fc_o, fc_reg_i[6:4]);
      end else begin
        wr++;
        check(bus_fc_o, fc_reg_i[2:0]);
        if (bus16_i && src_size_i == SIZE_WORD && dst_size_i == SIZE_WORD)
          check(bus_wdata_o, la[15:0] ^ 16'h5a3c);
      end
      check(dma_acknowledge_line_n_o, !(reqg_i[1] && bus_read_o != periph_is_dst_i));
      check(bus_word_o, bus16_i && !bus_addr_o[0] &&
        ((bus_read_o ? src_size_i : dst_size_i) == SIZE_WORD));
      if (!done_oe_n_o) begin
        lastc++;
        check(rd + wr, exp_tot);
        check({bus_read_o, done_out_n_o}, 2'h0);
      end
    end
    irqs += irq_o;
    dones += block_done_o;
  end
  task automatic run_block(input logic [1:0] rq, ss, ds, input logic b16,
    input logic si, di, input logic [CNT_W-1:0] cnt);
    logic sw, dw, wide;
    logic [PTR_W-1:0] sp, dp;
    int ops, n;
    sw = ss == SIZE_WORD;
    dw = ds == SIZE_WORD;
    wide = b16 && (sw || dw);
    ops = cnt / (wide ? 2 : 1);
    exp_tot = !wide ? 2 * cnt : (sw && dw) ? cnt : 3 * cnt / 2;
    seed = lfsr(seed);
    sp = (cnt == 16'h4) ? 24'hfffffe : seed[23:0] & {23'h7fffff, !b16};
    seed = lfsr(seed);
    dp = seed[31:8] & {23'h7fffff, !b16};
    {rd, wr, lastc, irqs, dones} = '0;
    @(posedge ref_clk_i);
    {reqg_i, src_size_i, dst_size_i, bus16_i} <= {rq, ss, ds, b16};
    {src_inc_en_i, dst_inc_en_i, src_ptr_i, dst_ptr_i} <= {si, di, sp, dp};
    {byte_count_i, periph_is_dst_i, intr_en_i} <= {cnt, seed[1:0]};
    fc_reg_i <= seed[15:8];
    start_i <= 1'b0;
    @(posedge ref_clk_i);
    start_i <= 1'b1;
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (!block_done_o && n < 5000);
    if (n == 5000) begin
      bad_count++;
      complete_run();
    end
    @(posedge ref_clk_i);
    start_i <= 1'b0;
    @(negedge ref_clk_i);
    check(src_ptr_o, step(sp, si, (wide && !sw) ? 4 : wide ? 2 : 1, ops));
    check(dst_ptr_o, step(dp, di, (wide && !dw) ? 4 : wide ? 2 : 1, ops));
    check(count_o, 16'h0);
    check(rd + wr, exp_tot);
    check(lastc, 1);
    check({dones, irqs, busy_o, bus_error_o},
          {32'd1, 32'(intr_en_i), 2'h0});
  endtask
  initial begin
    {ref_clk_i, resetn_i, start_i, go, bus_err_i, dma_request_line_n_i} = 6'h1;
    {reqg_i, src_size_i, dst_size_i, fc_reg_i} = '0;
    {src_inc_en_i, dst_inc_en_i, bus16_i, periph_is_dst_i, intr_en_i} = '0;
    {src_ptr_i, dst_ptr_i, byte_count_i, la} = '0;
    {bad_count, samples_checked} = '0;
    seed = 32'h6627;
    ds_r = 32'h6627;
    repeat (12) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    // Corner cases first: wrap, packing, unpacking, narrow bus, held ptrs
    run_block(REQG_INT_MAX, SIZE_WORD, SIZE_WORD, 1'b1, 1'b1, 1'b1, 16'h4);
    run_block(REQG_INT_LIMIT, SIZE_BYTE, SIZE_WORD, 1'b1, 1'b1, 1'b1, 16'h6);
    run_block(REQG_EXT_BURST, SIZE_WORD, SIZE_BYTE, 1'b1, 1'b1, 1'b1, 16'h8);
    run_block(REQG_EXT_STEAL, 2'h0, 2'h3, 1'b0, 1'b1, 1'b1, 16'h5);
    run_block(REQG_EXT_BURST, SIZE_WORD, SIZE_WORD, 1'b1, 1'b0, 1'b0, 16'h2);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      run_block(seed[1:0], seed[3:2], seed[5:4], seed[6], seed[7], seed[8],
                CNT_W'(2 * (seed[11:9] + 1)));
    end
    complete_run();
  end
endmodule
`default_nettype wire
